// ==== hdl/crst_top.sv ====
// Channel self-test: memory march test and signal-path signature test.
// Assumes register strobes and sample inputs are on the clk domain.
`timescale 1ns/1ps
module crst_top
    import crst_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic [SAMP_W-1:0] ext_i,
    input wire logic [SAMP_W-1:0] ext_q,
    input wire logic input_valid_gate,
    output logic [SAMP_W-1:0] chan_i,
    output logic [SAMP_W-1:0] chan_q,
    output logic chan_valid,
    output logic chan_sleep,
    output logic [BYP_W-1:0] stage_bypass,
    input wire logic [SAMP_W-1:0] fir_i,
    input wire logic [SAMP_W-1:0] fir_q,
    input wire logic fir_valid
);
    crst_ram_if coef_bus ();
    crst_ram_if samp_bus ();

    crst_ram u_coefficient_memory (
        .clk(clk),
        .bus(coef_bus.mem)
    );
    crst_ram u_sample_memory (
        .clk(clk),
        .bus(samp_bus.mem)
    );

    // Register decode
    wire wr_sig0 = wr_en && (addr == OFS_SIG_FIRST);
    wire wr_sig1 = wr_en && (addr == OFS_SIG_SECOND);
    wire wr_pctl = wr_en && (addr == OFS_PATH_CTRL);
    wire wr_mst = wr_en && (addr == OFS_MEM_STATUS);
    wire wr_cctl = wr_en && (addr == OFS_CHAN_CTRL);
    wire wr_hold = wr_en && (addr == OFS_HOLDOFF);

    // ---------------- Memory test ----------------
    crst_mt_state_t mt_state_q, mt_state_d;
    logic [RAM_AW-1:0] mt_addr_q, mt_addr_d;
    logic mt_pass_q, mt_pass_d;
    logic cmp_en_q;
    logic [RAM_AW-1:0] cmp_addr_q;
    logic cmp_pass_q;
    logic coef_fail_q, samp_fail_q, mt_busy_q;

    wire mt_start = wr_mst && wdata[MS_BUSY] && !mt_busy_q; // [RL2]
    wire mt_last_addr = (mt_addr_q == {RAM_AW{1'b1}});
    wire [RAM_DW-1:0] mt_wpat = {{(RAM_DW-RAM_AW){1'b0}}, mt_addr_q}
        ^ MT_PATTERN ^ (mt_pass_q ? MT_INVERT : '0);
    wire [RAM_DW-1:0] mt_expect = {{(RAM_DW-RAM_AW){1'b0}}, cmp_addr_q}
        ^ MT_PATTERN ^ (cmp_pass_q ? MT_INVERT : '0);
    wire mt_reading = (mt_state_q == MT_READ);

    // Both memories share one sequencer and are tested together
    assign coef_bus.addr = mt_addr_q;
    assign samp_bus.addr = mt_addr_q;
    assign coef_bus.wdata = mt_wpat;
    assign samp_bus.wdata = mt_wpat;
    assign coef_bus.we = (mt_state_q == MT_WRITE);
    assign samp_bus.we = (mt_state_q == MT_WRITE);

    // March sequencer: write pass, read pass, then complement
    always_comb begin
        mt_state_d = mt_state_q;
        mt_addr_d = mt_addr_q;
        mt_pass_d = mt_pass_q;
        case (mt_state_q)
            MT_IDLE: begin
                if (mt_start) begin
                    mt_state_d = MT_WRITE;
                    mt_addr_d = '0;
                    mt_pass_d = 1'b0;
                end
            end
            MT_WRITE: begin
                mt_addr_d = mt_addr_q + 1'b1;
                if (mt_last_addr) begin
                    mt_state_d = MT_READ;
                end
            end
            MT_READ: begin
                mt_addr_d = mt_addr_q + 1'b1;
                if (mt_last_addr && mt_pass_q) begin
                    mt_state_d = MT_LAST;
                end else if (mt_last_addr) begin
                    mt_state_d = MT_WRITE;
                    mt_pass_d = 1'b1;
                end
            end
            MT_LAST: mt_state_d = MT_IDLE;
            default: mt_state_d = MT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mt_state_q <= MT_IDLE;
            mt_addr_q <= '0;
            mt_pass_q <= 1'b0;
        end else begin
            mt_state_q <= mt_state_d;
            mt_addr_q <= mt_addr_d;
            mt_pass_q <= mt_pass_d;
        end
    end

    // Compare stage lines up with the registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_en_q <= 1'b0;
            cmp_addr_q <= '0;
            cmp_pass_q <= 1'b0;
        end else begin
            cmp_en_q <= mt_reading;
            cmp_addr_q <= mt_addr_q;
            cmp_pass_q <= mt_pass_q;
        end
    end

    wire coef_miss = cmp_en_q && (coef_bus.rdata != mt_expect);
    wire samp_miss = cmp_en_q && (samp_bus.rdata != mt_expect);

    // Busy while running, fail flags sticky until the next start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mt_busy_q <= 1'b0;
            coef_fail_q <= 1'b0;
            samp_fail_q <= 1'b0;
        end else if (mt_start) begin
            mt_busy_q <= 1'b1; // [RL4]
            coef_fail_q <= 1'b0;
            samp_fail_q <= 1'b0;
        end else begin
            if (mt_state_q == MT_LAST) begin
                mt_busy_q <= 1'b0; // [RL4]
            end
            coef_fail_q <= coef_fail_q | coef_miss; // [RL5]
            samp_fail_q <= samp_fail_q | samp_miss; // [RL5]
        end
    end

    // ---------------- Channel start and source ----------------
    logic sleep_q, sync_en_q, src_sine_q, src_prng_q;
    logic [BYP_W-1:0] bypass_q;
    logic [HOLD_W-1:0] holdoff_q, hold_cnt_q;
    logic hold_run_q;

    wire soft_sync = wr_cctl && wdata[CC_SOFT_SYNC] && wdata[CC_SYNC_EN];
    wire hold_fire = hold_run_q && (hold_cnt_q == HOLD_FIRE);

    // Soft sync loads the hold-off count, wake when it reaches one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_run_q <= 1'b0;
            hold_cnt_q <= HOLDOFF_RST;
        end else if (soft_sync) begin
            hold_run_q <= 1'b1; // [RL16]
            hold_cnt_q <= holdoff_q;
        end else if (hold_fire) begin
            hold_run_q <= 1'b0;
        end else if (hold_run_q) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // Channel control register; sleep set after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b1;
            sync_en_q <= 1'b0;
            src_sine_q <= 1'b0;
            src_prng_q <= 1'b0;
            bypass_q <= '0;
            holdoff_q <= HOLDOFF_RST;
        end else begin
            if (hold_fire) begin
                sleep_q <= 1'b0; // [RL16]
            end else if (wr_cctl) begin
                sleep_q <= wdata[CC_SLEEP];
            end
            if (wr_cctl) begin
                sync_en_q <= wdata[CC_SYNC_EN];
                src_sine_q <= wdata[CC_SRC_SINE];
                src_prng_q <= wdata[CC_SRC_PRNG];
                bypass_q <= wdata[CC_BYP_LSB +: BYP_W]; // [RL8]
            end
            if (wr_hold) begin
                holdoff_q <= wdata[HOLD_W-1:0];
            end
        end
    end

    // ---------------- Test sources ----------------
    logic [SAMP_W-1:0] prng_q;
    logic [3:0] phase_q;
    wire prng_fb = ^(prng_q & PRNG_TAPS);
    wire [3:0] cos_phase = phase_q + COS_SHIFT;

    // Generators advance only while the channel is awake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prng_q <= PRNG_SEED;
            phase_q <= '0;
        end else if (!sleep_q) begin
            prng_q <= {prng_q[SAMP_W-2:0], prng_fb};
            phase_q <= phase_q + 1'b1;
        end
    end

    wire [SAMP_W-1:0] src_i = src_prng_q ? prng_q : // [RL14]
        src_sine_q ? SINE_TBL[phase_q] : ext_i; // [RL15]
    wire [SAMP_W-1:0] prng_rev = {<<{prng_q}};
    wire [SAMP_W-1:0] src_q = src_prng_q ? prng_rev :
        src_sine_q ? SINE_TBL[cos_phase] : ext_q;
    wire src_valid = !sleep_q &&
        (src_prng_q || src_sine_q || input_valid_gate); // [RL17]

    // Samples to the channel, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_i <= '0;
            chan_q <= '0;
            chan_valid <= 1'b0;
        end else begin
            chan_i <= src_valid ? src_i : '0;
            chan_q <= src_valid ? src_q : '0;
            chan_valid <= src_valid; // [RL16]
        end
    end

    // ---------------- Signatures ----------------
    logic [CNT_W-1:0] path_cnt_q, remain_q;
    logic [RAM_DW-1:0] sig_q [NPATH];
    wire observe = fir_valid && (remain_q != '0); // [RL12]
    wire [SAMP_W-1:0] fir_data [NPATH];
    wire wr_sig [NPATH];
    assign fir_data[0] = fir_i;
    assign fir_data[1] = fir_q;
    assign wr_sig[0] = wr_sig0;
    assign wr_sig[1] = wr_sig1;

    // Observed-output count, reloaded by each path control write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            path_cnt_q <= '0;
            remain_q <= '0;
        end else if (wr_pctl) begin
            path_cnt_q <= wdata[CNT_W-1:0]; // [RL12]
            remain_q <= wdata[CNT_W-1:0];
        end else if (observe) begin
            remain_q <= remain_q - 1'b1;
        end
    end

    // One signature register per path, frozen when the count ends
    for (genvar p = 0; p < NPATH; p++) begin : g_sig
        wire [RAM_DW-1:0] shifted = {sig_q[p][RAM_DW-2:0], 1'b0}
            ^ (sig_q[p][RAM_DW-1] ? MISR_POLY : '0);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sig_q[p] <= SIG_RST;
            end else if (wr_sig[p]) begin
                sig_q[p] <= wdata[RAM_DW-1:0];
            end else if (observe) begin
                sig_q[p] <= shifted ^ fir_data[p]; // [RL7] [RL18] [RL19]
            end
        end
    end

    // ---------------- Read-back ----------------
    wire path_done = (path_cnt_q != '0) && (remain_q == '0);
    wire [DATA_W-1:0] cctl_rd = {{(DATA_W-CC_PATH_DONE-1){1'b0}},
        path_done, bypass_q, src_prng_q, src_sine_q, sync_en_q,
        4'b0000, sleep_q};
    wire [DATA_W-1:0] rd_mux =
        (addr == OFS_SIG_FIRST) ? {16'h0000, sig_q[0]} :
        (addr == OFS_SIG_SECOND) ? {16'h0000, sig_q[1]} :
        (addr == OFS_PATH_CTRL) ? {12'h000, path_cnt_q} :
        (addr == OFS_MEM_STATUS) ? {29'h0, samp_fail_q, coef_fail_q,
                                    mt_busy_q} : // [RL4] [RL5]
        (addr == OFS_CHAN_CTRL) ? cctl_rd :
        (addr == OFS_HOLDOFF) ? {16'h0000, holdoff_q} : '0;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd_en ? rd_mux : '0;
        end
    end

    // Memory test and path test share nothing [RL6]
    assign chan_sleep = sleep_q;
    assign stage_bypass = bypass_q;
endmodule // crst_top

// ==== hdl/crst_pkg.sv ====
// Constants, register map and types for the channel RAM self-test block.
// Assumes a single 20 MHz clock and a simple strobe register port.
// How it works
// RL1: Software sleeps each channel under test before the memory test.
// RL2: Setting status bit 0 starts the test over both channel memories.
// RL3: Software waits 1600 clocks before judging the status register.
// RL4: Status bit 0 reads high while the memory test runs, low after.
// RL5: Bit 1 flags coefficient memory failure, bit 2 sample memory failure.
// RL6: Memory test and signal-path test run independently and concurrently.
// RL7: Filter outputs compress into separate I and Q signatures.
// RL8: Processing stages can be bypassed to isolate a faulty stage.
// RL9: Software configures channels as in use and keeps them asleep.
// RL10: Software programs the start hold-off counter to one first.
// RL11: Software clears both signature registers before the path test.
// RL12: A nonzero 20-bit count enables the path test, counting outputs.
// RL13: Software issues the soft sync and sets the channel sync bits.
// RL14: Bits 6,7 clear pick external vectors; bit 7 picks pseudo-random.
// RL15: Bit 6 set, bit 7 clear injects an internal full-scale sine.
// RL16: On soft sync the channel leaves sleep and processes test input.
// RL17: With external vectors, input valid gates stay inactive until ready.
// RL18: After the count the signatures are deterministic for given input.
// RL19: Each path uses a 16-bit signature register updated on valid outputs.
package crst_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMP_W = 16;
    localparam int RAM_AW = 7;
    localparam int RAM_DW = 16;
    localparam int CNT_W = 20;
    localparam int HOLD_W = 16;
    localparam int BYP_W = 4;
    localparam int NPATH = 2;

    // Register offsets (one address per 32-bit register on the register port)
    localparam logic [ADDR_W-1:0] OFS_SIG_FIRST = 8'ha5;
    localparam logic [ADDR_W-1:0] OFS_SIG_SECOND = 8'ha6;
    localparam logic [ADDR_W-1:0] OFS_PATH_CTRL = 8'ha7;
    localparam logic [ADDR_W-1:0] OFS_MEM_STATUS = 8'ha8;
    localparam logic [ADDR_W-1:0] OFS_CHAN_CTRL = 8'ha9;
    localparam logic [ADDR_W-1:0] OFS_HOLDOFF = 8'haa;

    // Memory test status fields
    localparam int MS_BUSY = 0;
    localparam int MS_COEF_FAIL = 1;
    localparam int MS_SAMP_FAIL = 2;

    // Channel control fields
    localparam int CC_SLEEP = 0;
    localparam int CC_SOFT_SYNC = 4;
    localparam int CC_SYNC_EN = 5;
    localparam int CC_SRC_SINE = 6;
    localparam int CC_SRC_PRNG = 7;
    localparam int CC_BYP_LSB = 8;
    localparam int CC_PATH_DONE = 12;

    // Reset values and hold-off fire count
    localparam logic [HOLD_W-1:0] HOLDOFF_RST = 16'h0001;
    localparam logic [HOLD_W-1:0] HOLD_FIRE = 16'h0001;
    localparam logic [RAM_DW-1:0] SIG_RST = 16'h0000;
    localparam logic [SAMP_W-1:0] PRNG_SEED = 16'hace1;

    // Signature polynomial x^16+x^12+x^5+1, pseudo-random taps
    localparam logic [RAM_DW-1:0] MISR_POLY = 16'h1021;
    localparam logic [SAMP_W-1:0] PRNG_TAPS = 16'hb400;

    // Memory test patterns, second pass is the complement
    localparam logic [RAM_DW-1:0] MT_PATTERN = 16'h5a5a;
    localparam logic [RAM_DW-1:0] MT_INVERT = 16'hffff;

    // Full-scale sine, 16 points per period, cosine for quadrature
    localparam logic [SAMP_W-1:0] SINE_TBL [16] = '{
        16'h0000, 16'h30fb, 16'h5a81, 16'h7640,
        16'h7fff, 16'h7640, 16'h5a81, 16'h30fb,
        16'h0000, 16'hcf05, 16'ha57f, 16'h89c0,
        16'h8001, 16'h89c0, 16'ha57f, 16'hcf05};
    localparam logic [3:0] COS_SHIFT = 4'h4;

    typedef enum {MT_IDLE, MT_WRITE, MT_READ, MT_LAST} crst_mt_state_t;
endpackage

// ==== hdl/crst_ram_if.sv ====
// Port bundle between the self-test sequencer and one channel memory.
// Assumes read data arrive one clock after the address.
`timescale 1ns/1ps
interface crst_ram_if;
    import crst_pkg::*;
    logic [RAM_AW-1:0] addr;
    logic [RAM_DW-1:0] wdata;
    logic we;
    logic [RAM_DW-1:0] rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ==== hdl/crst_ram.sv ====
// Single-port channel memory with registered read data.
// Assumes one clock domain; write and read share the address.
`timescale 1ns/1ps
module crst_ram
    import crst_pkg::*;
(
    input wire logic clk,
    crst_ram_if.mem bus
);
    logic [RAM_DW-1:0] mem_q [2**RAM_AW];
    logic [RAM_DW-1:0] rdata_q;

    // Write on strobe, read data registered every clock
    always_ff @(posedge clk) begin
        if (bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.addr];
    end

    assign bus.rdata = rdata_q;
endmodule // crst_ram

// ==== bench/crst_sva.sv ====
// Checker for the channel self-test block, watching its top ports only.
// Assumes one clock domain; attached to every crst_top by the bind below.
`timescale 1ns/1ps
module crst_sva
    import crst_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [SAMP_W-1:0] ext_i,
    input wire logic [SAMP_W-1:0] ext_q,
    input wire logic input_valid_gate,
    input wire logic [SAMP_W-1:0] chan_i,
    input wire logic [SAMP_W-1:0] chan_q,
    input wire logic chan_valid,
    input wire logic chan_sleep,
    input wire logic [BYP_W-1:0] stage_bypass,
    input wire logic [SAMP_W-1:0] fir_i,
    input wire logic [SAMP_W-1:0] fir_q,
    input wire logic fir_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [10:0] mt_cnt_q;
    logic [HOLD_W-1:0] hold_q;
    logic [1:0] src_q;
    logic stat_rd_q;
    // Decodes of the register strobes
    wire wr_ctrl = wr_en && (addr == OFS_CHAN_CTRL);
    wire mt_idle = (mt_cnt_q == 11'h000) || (mt_cnt_q > 11'h258);
    wire mt_go = wr_en && (addr == OFS_MEM_STATUS) && wdata[0] && mt_idle;
    // Pseudo-random quadrature sample expected as the bit reverse of in-phase
    wire [SAMP_W-1:0] i_rev = {<<{chan_i}};
    // Shadow of memory test age, hold-off value and source select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mt_cnt_q <= 11'h000;
            hold_q <= HOLDOFF_RST;
            src_q <= 2'b00;
            stat_rd_q <= 1'b0;
        end else begin
            stat_rd_q <= rd_en && (addr == OFS_MEM_STATUS);
            if (mt_go) begin
                mt_cnt_q <= 11'h001;
            end else if (mt_cnt_q != 11'h000 && mt_cnt_q != 11'h7ff) begin
                mt_cnt_q <= mt_cnt_q + 11'h001;
            end
            if (wr_en && addr == OFS_HOLDOFF) begin
                hold_q <= wdata[HOLD_W-1:0];
            end
            if (wr_ctrl) begin
                src_q <= wdata[7:6];
            end
        end
    end
    a_rdata_idle_zero: assert property (
        !$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_mem_busy_high: assert property (stat_rd_q &&
        mt_cnt_q >= 11'h002 && mt_cnt_q <= 11'h1f4 |-> rdata[MS_BUSY])
        else $error("busy low in test");
    a_mem_done_pass: assert property (stat_rd_q && mt_cnt_q > 11'h212
        |-> rdata[2:0] == 3'b000) else $error("memory test not done or fail");
    a_sync_wake: assert property (wr_ctrl && wdata[4] && wdata[5] &&
        chan_sleep && hold_q == 16'h0001 |-> ##1 chan_sleep ##1 !chan_sleep)
        else $error("channel did not wake two cycles after sync");
    a_sleep_write: assert property (wr_ctrl && !wdata[5] |=>
        chan_sleep == $past(wdata[0])) else $error("sleep bit not loaded");
    a_bypass_load: assert property (wr_ctrl |=>
        stage_bypass == $past(wdata[11:8])) else $error("bypass not loaded");
    a_ext_pass: assert property (src_q == 2'b00 &&
        $past(src_q) == 2'b00 &&
        !chan_sleep && $past(!chan_sleep) |-> chan_valid ==
        $past(input_valid_gate) && (!chan_valid || (chan_i == $past(ext_i)
        && chan_q == $past(ext_q)))) else $error("external vector not passed");
    a_int_valid: assert property (src_q != 2'b00 &&
        $past(src_q) == src_q &&
        !chan_sleep && $past(!chan_sleep) |-> chan_valid)
        else $error("internal source sample missing");
    a_prng_step: assert property (src_q == 2'b10 &&
        $past(src_q) == 2'b10 && chan_valid && $past(chan_valid) |->
        chan_i == {$past(chan_i[14:0]), ^($past(chan_i) & PRNG_TAPS)} &&
        chan_q == i_rev) else $error("pseudo-random step wrong");
    a_sleep_quiet: assert property (chan_sleep && $past(chan_sleep)
        |-> !chan_valid) else $error("sample presented while asleep");
    c_mem_start: cover property (mt_go);
    c_mem_done: cover property (stat_rd_q && mt_cnt_q > 11'h212);
    c_sync: cover property (wr_ctrl && wdata[4] && wdata[5]);
    c_fir: cover property (fir_valid && !chan_sleep);
endmodule // crst_sva
bind crst_top crst_sva u_sva (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_i(ext_i), .ext_q(ext_q), .input_valid_gate(input_valid_gate),
    .chan_i(chan_i), .chan_q(chan_q), .chan_valid(chan_valid),
    .chan_sleep(chan_sleep), .stage_bypass(stage_bypass), .fir_i(fir_i),
    .fir_q(fir_q), .fir_valid(fir_valid));

// ==== bench/channel_ram_self_test_tb.sv ====
// Self-checking bench for the channel self-test block.
// Assumes the checker is bound in; reads are judged from a note queue.
`timescale 1ns/1ps
module channel_ram_self_test_tb;
    import crst_pkg::*;
    typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} crst_note_t;
    logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, rd_seen = 0;
    logic fir_valid = 0, input_valid_gate = 0, chan_valid, chan_sleep;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic [15:0] ext_i = 0, ext_q = 0, fir_i = 0, fir_q = 0, chan_i, chan_q;
    logic [15:0] ei, eq, sum_i = 0, sum_q = 0;
    logic [3:0] stage_bypass, byp;
    logic [1:0] srcs [3] = '{2'b01, 2'b10, 2'b00};
    logic top = 0, sine_on = 0;
    int seed = 56, n_errors = 0, comparisons = 0, cycles = 0, win = 0, n, got;
    crst_note_t notes [$];
    crst_note_t note;
    crst_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_i(ext_i),
        .ext_q(ext_q), .input_valid_gate(input_valid_gate), .chan_i(chan_i),
        .chan_q(chan_q), .chan_valid(chan_valid), .chan_sleep(chan_sleep),
        .stage_bypass(stage_bypass), .fir_i(fir_i), .fir_q(fir_q),
        .fir_valid(fir_valid));
    // 20 MHz clock
    always #25 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] ex, got_v);
        comparisons++;
        if (got_v !== ex) begin
            $display("[FAIL] %s expected %h seen %h", nm, ex, got_v);
            n_errors++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input string nm,
        input logic [31:0] ex, mk);
        notes.push_back('{nm, ex & mk, mk});
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic idle(input int c);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (c) @(posedge clk);
    endtask
    function automatic logic [15:0] step(logic [15:0] s, d);
        return ({s[14:0], 1'b0} ^ (s[15] ? MISR_POLY : 16'h0000)) ^ d;
    endfunction
    // Result watcher: read answers, sine windows and the run limit
    always @(posedge clk) begin
        if (rd_seen && notes.size() > 0) begin
            note = notes.pop_front();
            chk(note.nm, note.ex, rdata & note.mk);
        end
        rd_seen <= rd_en;
        if (sine_on && chan_valid) begin
            sum_i = sum_i + chan_i;
            sum_q = sum_q + chan_q;
            top = top | (chan_i == 16'h7fff);
            win++;
            if (win == 16) begin
                chk("sine i sum", 32'h0, {16'h0, sum_i});
                chk("sine q sum", 32'h0, {16'h0, sum_q});
                chk("sine peak", 32'h1, {31'h0, top});
                win = 0;
                sum_i = 0;
                sum_q = 0;
                top = 0;
            end
        end else begin
            win = 0;
            sum_i = 0;
            sum_q = 0;
            top = 0;
        end
        cycles++;
        if (cycles > 6000) begin
            n_errors++;
            results();
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFS_CHAN_CTRL, "ctrl reset", 32'h0000_0001, 32'h0000_1fff);
        rd(OFS_HOLDOFF, "holdoff reset", 32'h0000_0001, 32'hffff_ffff);
        rd(8'h3c, "unmapped", 32'h0000_0000, 32'hffff_ffff);
        idle(2);
        chk("bypass reset", 32'h0, {28'h0, stage_bypass});
        $display("reset test done");
        wr(OFS_CHAN_CTRL, 32'h0000_0001);
        wr(OFS_MEM_STATUS, 32'h0000_0001);
        rd(OFS_MEM_STATUS, "mem busy", 32'h0000_0001, 32'h0000_0007);
        foreach (srcs[s]) begin
            v = $random(seed);
            wr(OFS_SIG_FIRST, {16'h0, v[15:0]});
            rd(OFS_SIG_FIRST, "sig rw", {16'h0, v[15:0]}, 32'hffff_ffff);
            wr(OFS_SIG_FIRST, 32'h0);
            wr(OFS_SIG_SECOND, 32'h0);
            n = ($random(seed) & 15) + 1;
            wr(OFS_PATH_CTRL, n);
            wr(OFS_HOLDOFF, 32'h0000_0001);
            wr(OFS_CHAN_CTRL, 32'h0000_0001);
            input_valid_gate <= 1'b0;
            byp = $random(seed);
            wr(OFS_CHAN_CTRL, {20'h0, byp, srcs[s], 6'h31});
            rd(OFS_CHAN_CTRL, "done early", 32'h0, 32'h0000_1000);
            idle(2);
            chk("awake", 32'h0, {31'h0, chan_sleep});
            chk("bypass", {28'h0, byp}, {28'h0, stage_bypass});
            sine_on = (srcs[s] == 2'b01);
            ei = 16'h0;
            eq = 16'h0;
            got = 0;
            while (got < n + 2) begin
                v = $random(seed);
                fir_i <= v[15:0];
                fir_q <= v[31:16];
                fir_valid <= v[0];
                input_valid_gate <= v[1];
                ext_i <= $random(seed);
                ext_q <= $random(seed);
                if (v[0] && got < n) begin
                    ei = step(ei, v[15:0]);
                    eq = step(eq, v[31:16]);
                end
                got = got + v[0];
                @(posedge clk);
            end
            fir_valid <= 1'b0;
            idle(20);
            rd(OFS_SIG_FIRST, "sig i", {16'h0, ei}, 32'hffff_ffff);
            rd(OFS_SIG_SECOND, "sig q", {16'h0, eq}, 32'hffff_ffff);
            rd(OFS_CHAN_CTRL, "done", 32'h0000_1000, 32'h0000_1001);
            idle(1);
            sine_on = 0;
            $display("path test done, source %0d", srcs[s]);
        end
        idle(1600);
        rd(OFS_MEM_STATUS, "mem result", 32'h0, 32'h0000_0007);
        idle(2);
        $display("memory test done");
        results();
    end
endmodule // channel_ram_self_test_tb
